// *** design/silod_pkg.sv ***
// Shared constants for the serial-in latched output driver
package silod_pkg;
	localparam int unsigned STAGES      = 8;
	localparam int unsigned FIFO_DEPTH  = 32;
	localparam int unsigned EV_WIDTH    = 3;
	// Event word layout
	localparam int unsigned EV_BIT      = 0;
	localparam int unsigned EV_SHIFT    = 1;
	localparam int unsigned EV_LATCH    = 2;
	localparam logic [7:0]  SHIFT_RESET = 8'h00;
	localparam logic [7:0]  STORE_RESET = 8'h00;
endpackage

// *** design/silod_fifo.sv ***
// Parameterised FIFO with registered read data
`timescale 1ns/1ps
module silod_fifo #(
	parameter int unsigned WIDTH = 3,
	parameter int unsigned DEPTH = 32
) (
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	// ----------------------------------------
	// Flow control
	// ----------------------------------------
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign push     = in_valid && in_ready;
	assign pop      = (count != '0) && (!out_valid || out_ready);

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// ----------------------------------------
	// Output register
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (pop) begin
			out_valid <= 1'b1;
			out_data  <= mem[rd_ptr];
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end
endmodule

// *** design/silod_top.sv ***
// Serial-in shift register, storage register and open-drain output stage
`timescale 1ns/1ps
// How it works
// RULE1: Eight-stage shift register feeds eight-bit storage register
// RULE2: Shift clock shifts; transfer clock loads storage
// RULE3: Cascade output updates on each shift edge
// RULE4: Clear low holds shift stages at zero
// RULE5: Storage reaches buffer only while clear high
// RULE6: Output enable high forces all buffer bits low
// RULE7: Enable low: buffer follows storage combinationally
// RULE8: Buffer one sinks current; zero leaves off
// RULE9: Cascade output chains into next device input
// RULE10: First stage takes input, others shift along
// RULE11: Transfer edge captures all stages at once
module silod_top #(
	parameter int unsigned STAGES     = silod_pkg::STAGES,
	parameter int unsigned FIFO_DEPTH = silod_pkg::FIFO_DEPTH
) (
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	input  wire logic              serial_data_input,
	input  wire logic              serial_shift_clock,
	input  wire logic              latch_transfer_clock,
	input  wire logic              shift_clear_n,
	input  wire logic              output_enable_n,
	input  wire logic              drain_stall,
	output logic                   event_ready,
	output logic                   cascade_serial_output,
	output logic      [STAGES-1:0] drain_out,
	output logic      [STAGES-1:0] drain_oe,
	input  wire logic [STAGES-1:0] drain_in
);
	localparam int unsigned EW = silod_pkg::EV_WIDTH;

	logic              shift_clk_q;
	logic              latch_clk_q;
	logic              shift_rise;
	logic              latch_rise;
	logic [EW-1:0]     ev_in;
	logic [EW-1:0]     ev;
	logic              ev_valid;
	logic              core_take;
	logic              ev_shift;
	logic              ev_latch;
	logic [STAGES-1:0] shift_reg;
	logic [STAGES-1:0] storage;
	logic [STAGES-1:0] out_buffer;

	// ----------------------------------------
	// Edge detection of the two host clocks
	// ----------------------------------------
	// Pins idle low, so the cleared history cannot fake an edge
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			shift_clk_q <= 1'b0;
			latch_clk_q <= 1'b0;
		end else begin
			shift_clk_q <= serial_shift_clock;
			latch_clk_q <= latch_transfer_clock;
		end
	end

	assign shift_rise = serial_shift_clock && !shift_clk_q;
	assign latch_rise = latch_transfer_clock && !latch_clk_q;

	// ----------------------------------------
	// Event queue between pins and registers
	// ----------------------------------------
	// Edges are queued so a stalled core keeps them; edges seen while the
	// queue is full are dropped, which event_ready announces.
	always_comb begin
		ev_in                       = '0;
		ev_in[silod_pkg::EV_BIT]    = serial_data_input;
		ev_in[silod_pkg::EV_SHIFT]  = shift_rise;
		ev_in[silod_pkg::EV_LATCH]  = latch_rise;
	end

	silod_fifo #(
		.WIDTH (EW),
		.DEPTH (FIFO_DEPTH)
	) i_silod_fifo (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.in_data   (ev_in),
		.in_valid  (shift_rise || latch_rise),
		.in_ready  (event_ready),
		.out_data  (ev),
		.out_valid (ev_valid),
		.out_ready (!drain_stall)
	);

	assign core_take = ev_valid && !drain_stall;
	assign ev_shift  = ev[silod_pkg::EV_SHIFT];
	assign ev_latch  = ev[silod_pkg::EV_LATCH];

	// ----------------------------------------
	// Shift register
	// ----------------------------------------
	// Clear is looked at when an event is applied, so queued shifts drop too
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			shift_reg <= STAGES'(silod_pkg::SHIFT_RESET);
		end else if (!shift_clear_n) begin
			shift_reg <= '0; // RULE4
		end else if (core_take && ev_shift) begin
			shift_reg <= {shift_reg[STAGES-2:0], ev[silod_pkg::EV_BIT]}; // RULE10 RULE2 RULE1
		end
	end

	// Last stage drives the chain output
	assign cascade_serial_output = shift_reg[STAGES-1]; // RULE3 RULE9

	// ----------------------------------------
	// Storage register
	// ----------------------------------------
	// A combined event loads the contents from before the shift.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			storage <= STAGES'(silod_pkg::STORE_RESET);
		end else if (core_take && ev_latch) begin
			storage <= shift_reg; // RULE11 RULE2 RULE1
		end
	end

	// ----------------------------------------
	// Output buffer and open-drain stages
	// ----------------------------------------
	// One buffer bit and one sink-only stage per storage bit; the pull-up is outside
	for (genvar i = 0; i < STAGES; i++) begin : g_stage
		assign out_buffer[i] = storage[i] && !output_enable_n && shift_clear_n; // RULE5 RULE6 RULE7
		assign drain_out[i]  = 1'b0;
		assign drain_oe[i]   = out_buffer[i]; // RULE8

		a_stage_off: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE8
			!storage[i] |-> !drain_oe[i])
			else $error("stage sinks with its stored bit at zero");
	end

	// ----------------------------------------
	// Checks: reset and event queue
	// ----------------------------------------
	a_reset_state: assert property (@(posedge sys_clk) // RULE1
		sys_rst |=> shift_reg == '0 && storage == '0 && event_ready)
		else $error("state not cleared by reset");

	a_edge_queued: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE2
		(shift_rise || latch_rise) && event_ready |-> ##[1:2] ev_valid)
		else $error("accepted pin edge never reached the core");

	a_stall_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE2
		(drain_stall && shift_clear_n) |=> $stable(shift_reg) && $stable(storage))
		else $error("registers moved while the queue was stalled");

	a_queue_full: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE2
		!event_ready |-> ev_valid)
		else $error("queue full with nothing offered to the core");

	// ----------------------------------------
	// Checks: shift path
	// ----------------------------------------
	a_clear_zero: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE4
		!shift_clear_n |=> shift_reg == '0)
		else $error("shift stages not cleared");

	a_clear_wins: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE4
		(!shift_clear_n && core_take && ev_shift) |=> shift_reg == '0)
		else $error("shift applied while clear held low");

	a_shift_step: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE10
		(shift_clear_n && core_take && ev_shift)
		|=> shift_reg == {$past(shift_reg[STAGES-2:0]), $past(ev[silod_pkg::EV_BIT])})
		else $error("shift step wrong");

	a_shift_idle: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE2
		(shift_clear_n && !(core_take && ev_shift)) |=> $stable(shift_reg))
		else $error("shift stages moved without a shift event");

	a_cascade_edge: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE3
		(shift_clear_n && core_take && ev_shift)
		|=> cascade_serial_output == $past(shift_reg[STAGES-2]))
		else $error("cascade output not updated");

	a_cascade_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE3
		(shift_clear_n && !(core_take && ev_shift)) |=> $stable(cascade_serial_output))
		else $error("cascade output changed without a shift event");

	// ----------------------------------------
	// Checks: storage and outputs
	// ----------------------------------------
	a_latch_capture: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE11
		(core_take && ev_latch) |=> storage == $past(shift_reg))
		else $error("storage did not capture");

	a_latch_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE2
		!(core_take && ev_latch) |=> $stable(storage))
		else $error("storage changed without transfer");

	a_enable_off: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE6
		output_enable_n |-> drain_oe == '0)
		else $error("outputs on while disabled");

	a_follow_store: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE7
		(!output_enable_n && shift_clear_n && core_take && ev_latch)
		##1 (!output_enable_n && shift_clear_n) |-> drain_oe == $past(shift_reg))
		else $error("buffer not following storage");

	a_enable_pass: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE7
		($fell(output_enable_n) && shift_clear_n) |-> drain_oe == storage)
		else $error("buffer waited for a clock after enable");

	a_clear_gate: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE5
		!shift_clear_n |-> drain_oe == '0)
		else $error("storage passed while clear low");

	a_clear_pass: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE5
		($rose(shift_clear_n) && !output_enable_n) |-> drain_oe == storage)
		else $error("storage not passed once clear went high");

	a_drain_sink: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE8
		drain_out == '0 && (drain_oe & ~storage) == '0)
		else $error("drain stage drives high or sinks a zero bit");
endmodule

// *** testbench/silod_host.sv ***
// Host model driving the shift, transfer and clear pins
`timescale 1ns/1ps
module silod_host (
	input  wire logic sys_clk,
	output logic      sdi,
	output logic      sck,
	output logic      lck,
	output logic      clr_n
);
	initial begin
		sdi = 1'b0;
		sck = 1'b0;
		lck = 1'b0;
		clr_n = 1'b1;
	end
	// Each clock level lasts one cycle; data holds until the rise is sampled
	task automatic shift(input logic b);
		sdi = b;
		sck = 1'b1;
		@(posedge sys_clk) #1;
		sck = 1'b0;
		sdi = ~b;
		@(posedge sys_clk) #1;
	endtask
	task automatic set_clear(input logic level);
		clr_n = level;
	endtask
	task automatic latch();
		lck = 1'b1;
		@(posedge sys_clk) #1;
		lck = 1'b0;
		@(posedge sys_clk) #1;
	endtask
endmodule

// *** testbench/silod_top_bench.sv ***
// Self-checking bench for the serial-in latched output driver
`timescale 1ns/1ps
module silod_top_bench;
	logic       sys_clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       oe_n = 1'b0;
	logic       stall = 1'b0;
	logic       sdi, sck, lck, clr_n, ready, cas;
	logic [7:0] dout, doe, pin;
	logic [8:0] q[$];
	int         n_errors = 0;
	int         n_compared = 0;
	always #10 sys_clk = ~sys_clk;
	// Pulled-up open-drain wire
	assign pin = ~doe;
	silod_host i_silod_host (.sys_clk(sys_clk), .sdi(sdi), .sck(sck), .lck(lck), .clr_n(clr_n));
	silod_top i_silod_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .serial_data_input(sdi),
		.serial_shift_clock(sck), .latch_transfer_clock(lck), .shift_clear_n(clr_n),
		.output_enable_n(oe_n), .drain_stall(stall), .event_ready(ready),
		.cascade_serial_output(cas), .drain_out(dout), .drain_oe(doe), .drain_in(pin));
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("errors=%0d compared=%0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic send(input logic [7:0] b, input logic [8:0] exp);
		for (int i = 7; i >= 0; i--) begin
			i_silod_host.shift(b[i]);
		end
		q.push_back(exp);
		i_silod_host.latch();
	endtask
	// Result shows two cycles after the transfer edge is sampled; the check runs a cycle later
	always @(posedge lck) begin
		repeat (4) @(posedge sys_clk);
		#2;
		check({cas, doe}, q.pop_front());
	end
	initial begin
		repeat (100000) @(posedge sys_clk);
		n_errors++;
		tally_and_finish;
	end
	initial begin
		logic [7:0] b;
		int         k;
		k = $urandom(32'h9B3F);
		repeat (10) @(posedge sys_clk);
		#1;
		sys_rst = 1'b0;
		check({cas, doe}, 9'h000);
		for (k = 0; k < 6; k++) begin
			b = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
			send(b, {b[7], b});
		end
		i_silod_host.shift(1'b0);
		repeat (2) @(posedge sys_clk);
		#1;
		check({8'h00, cas}, {8'h00, b[6]});
		check({1'b0, dout}, 9'h000);
		oe_n = 1'b1;
		@(posedge sys_clk) #1;
		check({1'b0, doe}, 9'h000);
		oe_n = 1'b0;
		@(posedge sys_clk) #1;
		check({1'b0, doe}, {1'b0, b});
		i_silod_host.set_clear(1'b0);
		@(posedge sys_clk) #1;
		check({1'b0, doe}, 9'h000);
		// A shift presented while clear is low must be dropped
		i_silod_host.shift(1'b1);
		@(posedge sys_clk) #1;
		i_silod_host.set_clear(1'b1);
		@(posedge sys_clk) #1;
		check({1'b0, doe}, {1'b0, b});
		q.push_back(9'h000);
		i_silod_host.latch();
		repeat (4) @(posedge sys_clk);
		#1;
		stall = 1'b1;
		repeat (40) i_silod_host.shift(1'b1);
		check({8'h00, ready}, 9'h000);
		stall = 1'b0;
		for (k = 0; k < 100 && ready !== 1'b1; k++) begin
			@(posedge sys_clk);
		end
		if (k == 100) begin
			n_errors++;
			tally_and_finish;
		end
		repeat (40) @(posedge sys_clk);
		#1;
		check({8'h00, cas}, 9'h001);
		tally_and_finish;
	end
endmodule
